// file: counter_freq_diag_record.sv
// diagnostic record builder for the counter and frequency-measurement functions
// assumes event and pending inputs come from logic on ref_clk; base bytes 0, 2, 3 come from the base record owner
`timescale 1ns/100ps

// How it works
// R1 - the extended record is sixteen bytes, the four base bytes followed by twelve function bytes.
// R2 - bytes zero to three of the extended record equal the base record as it stands when read.
// R3 - byte four bits six to zero hold channel type 76h in both record flavours.
// R4 - byte four bit seven tells whether more channel types follow.
// R5 - byte five always reads 08h diagnostic bits per channel.
// R6 - byte six always reads 04h channels.
// R7 - in the counter record byte seven bits zero to three flag errors of counters zero to three.
// R8 - in the counter record bytes eight to ten carry lost overflow in bit two and lost compare in bit three.
// R9 - in the counter record byte eleven carries the five lost-event flags of counter three.
// R10 - in the frequency record byte seven bits zero to three flag errors of frequency meters zero to three.
// R11 - in the frequency record bytes eight to eleven bit zero flag lost end of measurement, the rest read zero.
// R12 - each lost-event flag is reported as a diagnostic interrupt cause.
// R13 - base byte one holds module class 1000b in bits three to zero and channel info present in bit four.
// R14 - a lost flag sets when an event recurs while its interrupt is pending and holds until the record is read.
// R15 - a channel-group error bit is set whenever any lost flag of that channel is set.

module counter_freq_diag_record
(
   input  wire logic                                    ref_clk,
   input  wire logic                                    sys_rst,
   input  wire logic                                    clkEn,
   input  wire logic [7:0]                              regAddr,
   input  wire logic [31:0]                             regWrData,
   input  wire logic                                    regWrite,
   input  wire logic                                    regRead,
   output logic      [31:0]                             regRdData,
   input  wire logic [diag_record_pkg::CNT_EVT_WIDTH-1:0] cntEvent,
   input  wire logic [diag_record_pkg::CNT_EVT_WIDTH-1:0] cntPending,
   input  wire logic [diag_record_pkg::FREQ_CHANNELS-1:0] freqEvent,
   input  wire logic [diag_record_pkg::FREQ_CHANNELS-1:0] freqPending,
   input  wire logic [7:0]                              baseByte0,
   input  wire logic [7:0]                              baseByte2,
   input  wire logic [7:0]                              baseByte3,
   output logic                                         irq
);
   import diag_record_pkg::*;

   logic [CNT_EVT_WIDTH-1:0] cntLost;
   logic [FREQ_CHANNELS-1:0] freqLost;
   logic [1:0]               control;
   logic [1:0]               irqStatus;
   logic [1:0]               irqMask;

   logic [CNT_EVT_WIDTH-1:0] cntLostSet;
   logic [FREQ_CHANNELS-1:0] freqLostSet;
   logic                     recordDone;
   logic                     statusRead;
   logic                     freqMode;
   logic                     moreTypes;

   logic [3:0]               cntGroupErr;
   logic [3:0]               freqGroupErr;
   logic                     anyLost;

   logic [7:0]               recByte [RECORD_BYTES];
   logic [31:0]              baseWord;
   logic [31:0]              next_rdData;

   assign freqMode  = control[CTRL_FREQ_MODE_BIT];
   assign moreTypes = control[CTRL_MORE_TYPES_BIT];

   // a recurring event while the previous one is still pending means a lost process interrupt
   assign cntLostSet  = cntEvent & cntPending;   // R14
   assign freqLostSet = freqEvent & freqPending; // R14

   // reading the last record word ends the record and releases the lost flags
   assign recordDone = regRead && (regAddr == REC_WORD3_ADDR);
   assign statusRead = regRead && (regAddr == IRQ_STATUS_ADDR);

   // lost flags: set wins over the clearing read so an event in that cycle survives
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cntLost  <= '0;
         freqLost <= '0;
      end
      else if (clkEn)
      begin
         cntLost  <= (recordDone ? '0 : cntLost) | cntLostSet;    // R14
         freqLost <= (recordDone ? '0 : freqLost) | freqLostSet;  // R14
      end
   end

   // control register
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         control <= CONTROL_RESET;
      end
      else if (clkEn && regWrite && regAddr == CONTROL_ADDR)
      begin
         control <= regWrData[1:0];
      end
   end

   // interrupt mask
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         irqMask <= IRQ_MASK_RESET;
      end
      else if (clkEn && regWrite && regAddr == IRQ_MASK_ADDR)
      begin
         irqMask <= regWrData[1:0];
      end
   end

   // sticky interrupt causes, cleared by reading the status, new causes win over the clear
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         irqStatus <= '0;
      end
      else if (clkEn)
      begin
         irqStatus[IRQ_CNT_LOST_BIT]  <= (irqStatus[IRQ_CNT_LOST_BIT] & ~statusRead)
                                         | (|cntLostSet);          // R12
         irqStatus[IRQ_FREQ_LOST_BIT] <= (irqStatus[IRQ_FREQ_LOST_BIT] & ~statusRead)
                                         | (|freqLostSet);         // R12
      end
   end

   assign irq = |(irqStatus & irqMask); // R12

   // channel-group errors follow the lost flags of their channel
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         cntGroupErr[i] = cntLost[CNT_OVF_LSB + i] | cntLost[CNT_CMP_LSB + i]; // R15
      end
      cntGroupErr[3] = cntGroupErr[3] | cntLost[CNT3_GATE_OPEN]
                       | cntLost[CNT3_GATE_CLOSE] | cntLost[CNT3_LATCH];      // R15
      freqGroupErr = freqLost;                                                 // R15
   end

   assign anyLost = freqMode ? (|freqLost) : (|cntLost);

   // base record; byte 1 is built here, the other bytes are owned elsewhere
   assign baseWord = {baseByte3,
                      baseByte2,
                      3'b000, anyLost, MODULE_CLASS_FN,   // R13
                      baseByte0};

   // record assembly
   always_comb
   begin
      // bytes 0..3 are the very same word as the base record, so both reads always agree
      recByte[0] = baseWord[7:0];    // R2
      recByte[1] = baseWord[15:8];   // R2
      recByte[2] = baseWord[23:16];  // R2
      recByte[3] = baseWord[31:24];  // R2
      recByte[4] = {moreTypes, CHANNEL_TYPE}; // R3 R4
      recByte[5] = DIAG_BITS_PER_CH;          // R5
      recByte[6] = CHANNEL_COUNT;             // R6
      for (int b = 12; b < RECORD_BYTES; b++)
      begin
         recByte[b] = 8'h00; // R11
      end
      if (freqMode)
      begin
         recByte[7] = {4'h0, freqGroupErr}; // R10
         for (int c = 0; c < FREQ_CHANNELS; c++)
         begin
            recByte[8 + c] = {7'h00, freqLost[c]}; // R11
         end
      end
      else
      begin
         recByte[7] = {4'h0, cntGroupErr}; // R7
         for (int c = 0; c < 3; c++)
         begin
            recByte[8 + c] = {4'h0, cntLost[CNT_CMP_LSB + c], cntLost[CNT_OVF_LSB + c], 2'b00}; // R8
         end
         recByte[11] = {3'b000,
                        cntLost[CNT3_LATCH],
                        cntLost[CNT_CMP_LSB + 3],
                        cntLost[CNT_OVF_LSB + 3],
                        cntLost[CNT3_GATE_CLOSE],
                        cntLost[CNT3_GATE_OPEN]};  // R9
      end
   end

   // read mux; unmapped addresses read zero
   always_comb
   begin
      next_rdData = 32'h0000_0000;
      case (regAddr)
         REC_WORD0_ADDR:  next_rdData = {recByte[3], recByte[2], recByte[1], recByte[0]};    // R1
         REC_WORD1_ADDR:  next_rdData = {recByte[7], recByte[6], recByte[5], recByte[4]};    // R1
         REC_WORD2_ADDR:  next_rdData = {recByte[11], recByte[10], recByte[9], recByte[8]};  // R1
         REC_WORD3_ADDR:  next_rdData = {recByte[15], recByte[14], recByte[13], recByte[12]}; // R1
         BASE_REC_ADDR:   next_rdData = baseWord;
         IRQ_STATUS_ADDR: next_rdData = {30'h0, irqStatus};
         IRQ_MASK_ADDR:   next_rdData = {30'h0, irqMask};
         CONTROL_ADDR:    next_rdData = {30'h0, control};
         default:         next_rdData = 32'h0000_0000;
      endcase
   end

   // with clkEn high, read data stands only in the cycle after the strobe, zero otherwise; with clkEn low the register holds
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         regRdData <= 32'h0000_0000;
      end
      else if (clkEn)
      begin
         regRdData <= regRead ? next_rdData : 32'h0000_0000;
      end
   end

endmodule // counter_freq_diag_record

// file: counter_freq_diag_record_assertions.sv
// checker for the diagnostic record block, sees the top ports only
// assumes clkEn stays high while reads are checked
`timescale 1ns/100ps
module counter_freq_diag_record_assertions
(
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        clkEn,
   input wire logic [7:0]  regAddr,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [31:0] regRdData,
   input wire logic [10:0] cntEvent,
   input wire logic [10:0] cntPending,
   input wire logic [3:0]  freqEvent,
   input wire logic [3:0]  freqPending,
   input wire logic [7:0]  baseByte0,
   input wire logic [7:0]  baseByte2,
   input wire logic [7:0]  baseByte3,
   input wire logic        irq
);
   import diag_record_pkg::*;
   logic       rdQ;
   logic [7:0] adQ;
   always_ff @(posedge ref_clk)
   begin
      rdQ <= regRead && clkEn && !sys_rst;
      adQ <= regAddr;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   rd_idle_a: assert property (!rdQ |-> regRdData == 32'h0) else $error("read data not idle");
   type_const_a: assert property (rdQ && adQ == REC_WORD1_ADDR |-> regRdData[6:0] == 7'h76
      && regRdData[23:8] == 16'h0408) else $error("byte 4..6 wrong");
   grp_rsvd_a: assert property (rdQ && adQ == REC_WORD1_ADDR |-> regRdData[31:28] == 4'h0) else $error("byte 7");
   base_copy_a: assert property (rdQ && adQ == REC_WORD0_ADDR |-> {regRdData[31:16], regRdData[7:0]} ==
      {$past(baseByte3), $past(baseByte2), $past(baseByte0)}) else $error("base bytes wrong");
   mod_class_a: assert property (rdQ && adQ == REC_WORD0_ADDR |-> regRdData[11:8] == 4'h8
      && regRdData[15:13] == 3'h0) else $error("module class wrong");
   evt_rsvd_a: assert property (rdQ && adQ == REC_WORD2_ADDR |-> (regRdData & 32'hE0F2_F2F2) == 32'h0)
      else $error("event byte reserved bits");
   tail_zero_a: assert property (rdQ && adQ == REC_WORD3_ADDR |-> regRdData == 32'h0) else $error("tail");
   lost_irq_a: assert property ($rose(irq) |-> $past(regWrite) || $past(|(cntEvent & cntPending)
      || |(freqEvent & freqPending))) else $error("irq without cause");
   cover property (rdQ && adQ == REC_WORD2_ADDR && regRdData != 32'h0);
   cover property ($rose(irq));
   cover property (rdQ && adQ == REC_WORD3_ADDR);
endmodule // counter_freq_diag_record_assertions

bind counter_freq_diag_record counter_freq_diag_record_assertions chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .clkEn(clkEn), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
   .cntEvent(cntEvent), .cntPending(cntPending), .freqEvent(freqEvent), .freqPending(freqPending),
   .baseByte0(baseByte0), .baseByte2(baseByte2), .baseByte3(baseByte3), .irq(irq));

// file: diag_record_pkg.sv
// constants for the counter / frequency-measurement diagnostic record block
// assumes a 32-bit register port with byte addresses, words little-endian (byte 0 in bits 7:0)
package diag_record_pkg;

   // register byte addresses
   localparam logic [7:0] REC_WORD0_ADDR  = 8'h00; // record bytes 0..3
   localparam logic [7:0] REC_WORD1_ADDR  = 8'h04; // record bytes 4..7
   localparam logic [7:0] REC_WORD2_ADDR  = 8'h08; // record bytes 8..11
   localparam logic [7:0] REC_WORD3_ADDR  = 8'h0C; // record bytes 12..15, read ends the record
   localparam logic [7:0] BASE_REC_ADDR   = 8'h10; // base record alone
   localparam logic [7:0] IRQ_STATUS_ADDR = 8'h14;
   localparam logic [7:0] IRQ_MASK_ADDR   = 8'h18;
   localparam logic [7:0] CONTROL_ADDR    = 8'h1C;

   // control register fields
   localparam int CTRL_FREQ_MODE_BIT  = 0; // 0 counter record, 1 frequency record
   localparam int CTRL_MORE_TYPES_BIT = 1; // byte 4 bit 7
   localparam logic [1:0] CONTROL_RESET   = 2'h0;
   localparam logic [1:0] IRQ_MASK_RESET  = 2'h0;

   // interrupt status fields
   localparam int IRQ_CNT_LOST_BIT  = 0;
   localparam int IRQ_FREQ_LOST_BIT = 1;

   // record constants
   localparam int         RECORD_BYTES     = 16;
   localparam logic [6:0] CHANNEL_TYPE     = 7'h76;
   localparam logic [7:0] DIAG_BITS_PER_CH = 8'h08;
   localparam logic [7:0] CHANNEL_COUNT    = 8'h04;
   localparam logic [3:0] MODULE_CLASS_FN  = 4'h8;

   // counter event vector layout
   localparam int CNT_EVT_WIDTH   = 11;
   localparam int CNT_OVF_LSB     = 0;  // counters 0..3 over/underflow/end value
   localparam int CNT_CMP_LSB     = 4;  // counters 0..3 comparison reached
   localparam int CNT3_GATE_OPEN  = 8;
   localparam int CNT3_GATE_CLOSE = 9;
   localparam int CNT3_LATCH      = 10;
   localparam int FREQ_CHANNELS   = 4;

endpackage

// file: event_source.sv
// event source standing in for the counter and frequency logic
// pending stays up until the firmware acknowledges, so a repeat is a lost interrupt
`timescale 1ns/100ps
module event_source
(
   input  wire logic        ref_clk,
   input  wire logic [10:0] cntReq,
   input  wire logic [3:0]  freqReq,
   input  wire logic        ack,
   output logic      [10:0] cntEvent,
   output logic      [10:0] cntPending,
   output logic      [3:0]  freqEvent,
   output logic      [3:0]  freqPending
);
   always_ff @(posedge ref_clk)
   begin
      cntEvent    <= cntReq;
      freqEvent   <= freqReq;
      cntPending  <= ack ? 11'h000 : cntPending | cntEvent;
      freqPending <= ack ? 4'h0 : freqPending | freqEvent;
   end
endmodule // event_source

// file: tb_top.sv
// self-checking bench for the diagnostic record block
// assumes one clock; events reach the block through the event source model
`timescale 1ns/100ps
module tb_top;
   import diag_record_pkg::*;
   logic        ref_clk, sysRst, regWrite, regRead, ack, irq, clkEn;
   logic [7:0]  regAddr;
   logic [31:0] regWrData, regRdData;
   logic [10:0] cntReq, cntEvent, cntPending;
   logic [3:0]  freqReq, freqEvent, freqPending;
   int          badCount, testsRun, cyc;
   int          pos [11] = '{2, 10, 18, 26, 3, 11, 19, 27, 24, 25, 28};
   counter_freq_diag_record dut (.ref_clk(ref_clk), .sys_rst(sysRst), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .cntEvent(cntEvent), .cntPending(cntPending), .freqEvent(freqEvent), .freqPending(freqPending),
      .baseByte0(8'hA5), .baseByte2(8'h3C), .baseByte3(8'h5A), .irq(irq));
   event_source src (.ref_clk(ref_clk), .cntReq(cntReq), .freqReq(freqReq), .ack(ack),
      .cntEvent(cntEvent), .cntPending(cntPending), .freqEvent(freqEvent), .freqPending(freqPending));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         badCount++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      {regAddr, regRead} <= {a, 1'b1};
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1 chk(regRdData, exp);
   endtask
   // two cycles after the request the lost flag has landed
   task automatic fire(input logic [10:0] c, input logic [3:0] f);
      @(posedge ref_clk);
      {cntReq, freqReq} <= {c, f};
      @(posedge ref_clk);
      {cntReq, freqReq} <= 15'h0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic clrAck;
      @(posedge ref_clk);
      ack <= 1'b1;
      @(posedge ref_clk);
      ack <= 1'b0;
   endtask
   task automatic closeOut;
      $display("checks %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         badCount++;
         closeOut();
      end
   end
   initial
   begin
      {sysRst, ack, regWrite, regRead, regAddr, regWrData, cntReq, freqReq} = {2'b11, 57'h0};
      clkEn = 1'b1;
      repeat (8) @(posedge ref_clk);
      {sysRst, ack} <= 2'b00;
      rd(IRQ_MASK_ADDR, 32'h0);
      rd(CONTROL_ADDR, 32'h0);
      rd(REC_WORD0_ADDR, 32'h5A3C_08A5);
      wr(REC_WORD1_ADDR, 32'hFFFF_FFFF);
      rd(REC_WORD1_ADDR, 32'h0004_0876);
      rd(REC_WORD3_ADDR, 32'h0);
      rd(8'h20, 32'h0);
      $display("reset test done");
      wr(IRQ_MASK_ADDR, 32'h0000_0003);
      wr(CONTROL_ADDR, 32'h0000_0002);
      rd(IRQ_MASK_ADDR, 32'h0000_0003);
      for (int i = 0; i < 11; i++)
      begin
         fire(11'h001 << i, 4'h0);
         rd(REC_WORD2_ADDR, 32'h0);
         fire(11'h001 << i, 4'h0);
         chk({31'h0, irq}, 32'h1);
         rd(REC_WORD2_ADDR, 32'h1 << pos[i]);
         rd(REC_WORD1_ADDR, {4'h0, 4'h1 << (i < 4 ? i : i < 8 ? i - 4 : 3), 24'h04_08F6});
         rd(REC_WORD0_ADDR, 32'h5A3C_18A5);
         rd(IRQ_STATUS_ADDR, 32'h1);
         rd(REC_WORD3_ADDR, 32'h0);
         rd(REC_WORD2_ADDR, 32'h0);
         clrAck();
      end
      $display("counter test done");
      wr(CONTROL_ADDR, 32'h0000_0001);
      for (int i = 0; i < 4; i++)
      begin
         repeat (2) fire(11'h000, 4'h1 << i);
         rd(REC_WORD2_ADDR, 32'h1 << (8 * i));
         rd(REC_WORD1_ADDR, {4'h0, 4'h1 << i, 24'h04_0876});
         rd(IRQ_STATUS_ADDR, 32'h2);
         rd(REC_WORD3_ADDR, 32'h0);
         clrAck();
      end
      // a repeat while the clock enable is low must leave no trace
      @(posedge ref_clk);
      clkEn <= 1'b0;
      repeat (2) fire(11'h000, 4'h2);
      @(posedge ref_clk);
      clkEn <= 1'b1;
      rd(REC_WORD2_ADDR, 32'h0);
      clrAck();
      wr(IRQ_MASK_ADDR, 32'h0);
      repeat (2) fire(11'h000, 4'h1);
      chk({31'h0, irq}, 32'h0);
      rd(IRQ_STATUS_ADDR, 32'h2);
      $display("freq and mask test done");
      closeOut();
   end
endmodule // tb_top
